// file: pkg/bcd_pkg.sv
`default_nettype none
package bcd_pkg;
    // configuration offsets (dword aligned byte addresses)
    localparam logic [7:0] BCD_OFF_BRIDGE_CTL = 8'h3C;
    localparam logic [7:0] BCD_OFF_CHIP_DIAG  = 8'h40;

    // bridge control bit positions
    localparam int BCD_B_FAST_B2B   = 23;
    localparam int BCD_B_SEC_RESET  = 22;
    localparam int BCD_B_MA_MODE    = 21;
    localparam int BCD_B_VGA_EN     = 19;
    localparam int BCD_B_ISA_EN     = 18;
    localparam int BCD_B_SERR_FWD   = 17;
    localparam int BCD_B_PAR_RESP   = 16;
    localparam int BCD_INTPIN_LSB   = 8;

    // chip/diagnostic bit positions
    localparam int BCD_D_PWE_HI     = 28;
    localparam int BCD_D_PWE_LO     = 25;
    localparam int BCD_D_BURST_LSB  = 16;
    localparam int BCD_D_PSERR_DIAG = 12;
    localparam int BCD_D_SPERR_DIAG = 11;
    localparam int BCD_D_PPERR_DIAG = 10;

    // writable masks
    localparam logic [31:0] BCD_BRIDGE_WMASK = 32'h006F_0000;
    localparam logic [31:0] BCD_DIAG_WMASK   = 32'h1E3F_1C00;
    localparam logic [31:0] BCD_RESET_VAL    = 32'h0000_0000;
    localparam logic [7:0]  BCD_INTPIN_VAL   = 8'h00;

    // vga decode constants
    localparam logic [31:0] BCD_VGA_MEM_LO   = 32'h000A_0000;
    localparam logic [31:0] BCD_VGA_MEM_HI   = 32'h000B_FFFF;
    localparam logic [31:0] BCD_VGA_IO_LO    = 32'h0000_03B0;
    localparam logic [31:0] BCD_VGA_IO_HI    = 32'h0000_03DF;
    localparam logic [31:0] BCD_VGA_HOLE_LO  = 32'h0000_03BC;
    localparam logic [31:0] BCD_VGA_HOLE_HI  = 32'h0000_03BF;

    // isa alias: address bits 9:8 nonzero means upper 768 bytes of a 1 KB block
    localparam int BCD_ISA_LSB = 8;

    localparam logic [31:0] BCD_ALL_ONES = 32'hFFFF_FFFF;

    // master-abort outcome codes
    typedef enum logic [1:0] {
        BCD_MA_NONE,
        BCD_MA_TABORT,
        BCD_MA_ONES,
        BCD_MA_DROP
    } bcd_ma_t;
endpackage : bcd_pkg
`default_nettype wire

// file: src/bcd_fwd_decode.sv
`timescale 1ns/100ps
`default_nettype none
module bcd_fwd_decode
    import bcd_pkg::*;
(
    input  wire logic        is_io,
    input  wire logic [31:0] addr,
    input  wire logic        in_window,
    input  wire logic        vga_en,
    input  wire logic        isa_en,
    output logic             forward
);
    logic vga_hit;
    logic isa_block;

    // vga decode stands apart from the windows
    // RL9: window-independent vga decode
    always_comb
    begin
        if (is_io)
            vga_hit = (addr >= BCD_VGA_IO_LO) && (addr <= BCD_VGA_IO_HI)
                      && !((addr >= BCD_VGA_HOLE_LO) && (addr <= BCD_VGA_HOLE_HI));
        else
            vga_hit = (addr >= BCD_VGA_MEM_LO) && (addr <= BCD_VGA_MEM_HI);
    end

    // isa filter only trims inside the programmed io window
    // RL10: upper 768 bytes blocked
    // RL11: inside window only
    assign isa_block = isa_en && is_io && in_window
                       && (addr[BCD_ISA_LSB+1:BCD_ISA_LSB] != 2'b00);

    assign forward = (vga_en && vga_hit) || (in_window && !isa_block);
endmodule : bcd_fwd_decode
`default_nettype wire

// file: src/bcd_regs.sv
// Operation
// RL1: fast back-to-back bit reads zero; never issue fast back-to-back secondary cycles.
// RL2: secondary reset bit floats secondary outputs and ends secondary transactions.
// RL3: secondary reset output held while bit set; only config write clears it.
// RL4: primary side and config registers keep working through secondary reset.
// RL5: setting secondary reset flushes all posted write buffers.
// RL6: master-abort mode set: master abort returns target abort to initiator.
// RL7: mode clear: aborted reads return all ones, aborted writes dropped.
// RL8: vga enable forwards vga memory and io ranges downstream.
// RL9: vga decode independent of programmed memory and io windows.
// RL10: isa enable blocks upper 768 bytes of each 1 KB io block.
// RL11: isa filtering only inside programmed io window.
// RL12: serr forward enable passes secondary address parity serr to primary.
// RL13: parity response low disables secondary parity checking.
// RL14: interrupt pin field reads 00h.
// RL15: posted-write error disable bits suppress primary error per condition.
// RL16: burst limit caps data transfers at 1..63; zero means unlimited.
// RL17: burst limit top two bits fixed at zero.
// RL18: primary serr diagnostic asserts serr on every primary address phase.
// RL19: secondary perr diagnostic asserts perr on secondary write data phases to us. Code withholds it while the secondary reset bit is set.
// RL20: primary perr diagnostic asserts perr on primary write data phases to us.
// RL21: type-zero config access reaches both registers; reserved bits read zero.
`timescale 1ns/100ps
`default_nettype none
module bcd_regs
    import bcd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    // type-zero configuration access from the primary bus
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    // secondary bus control
    output logic             sec_rst_n,
    output logic             sec_out_float,
    output logic             sec_xact_kill,
    output logic             post_flush,
    output logic             fast_b2b_allow,
    output logic             sec_parity_check_en,
    // forward decode request
    input  wire logic        dec_is_io,
    input  wire logic [31:0] dec_addr,
    input  wire logic        dec_in_window,
    output logic             dec_forward,
    // master abort handling
    input  wire logic        ma_seen,
    input  wire logic        ma_is_read,
    input  wire logic        ma_is_posted,
    output logic [1:0]       ma_outcome,
    output logic [31:0]      ma_read_data,
    // burst control
    input  wire logic        burst_start,
    input  wire logic        burst_xfer,
    output logic             burst_stop,
    // error events
    input  wire logic        sec_addr_par_serr,
    input  wire logic [3:0]  pw_err,
    input  wire logic        pri_addr_phase,
    input  wire logic        sec_wr_data_phase_us,
    input  wire logic        pri_wr_data_phase_us,
    output logic             pri_serr_n,
    output logic             sec_perr_n,
    output logic             pri_perr_n
);
    logic [31:0] bridge_r;
    logic [31:0] diag_r;
    logic [6:0]  burst_cnt_r;
    logic        sec_rst_q_r;
    logic        pri_serr_n_r;
    logic        sec_perr_n_r;
    logic        pri_perr_n_r;
    logic [31:0] ma_data_r;
    logic [31:0] be_mask;
    logic [5:0]  burst_lim;
    logic        sec_reset_bit;

    // byte enables widened into a bit mask
    function automatic logic [31:0] bcd_be_mask(input logic [3:0] be);
        bcd_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : bcd_be_mask

    // register image with read-only fields forced
    // RL14: interrupt pin zero
    function automatic logic [31:0] bcd_bridge_view(input logic [31:0] r);
        logic [31:0] v;
        v = r & BCD_BRIDGE_WMASK;
        v[BCD_B_FAST_B2B] = 1'b0;
        v[BCD_INTPIN_LSB +: 8] = BCD_INTPIN_VAL;
        bcd_bridge_view = v;
    endfunction : bcd_bridge_view

    assign be_mask       = bcd_be_mask(cfg_be);
    assign sec_reset_bit = bridge_r[BCD_B_SEC_RESET];

    // bridge control register; config writes are honoured even in sec reset
    // RL4: config kept alive
    always_ff @(posedge core_clk)
    begin
        if (rst)
            bridge_r <= BCD_RESET_VAL;
        else if (cfg_wr && cfg_addr == BCD_OFF_BRIDGE_CTL)
            bridge_r <= (bridge_r & ~(be_mask & BCD_BRIDGE_WMASK))
                        | (cfg_wdata & be_mask & BCD_BRIDGE_WMASK);
    end

    // chip/diagnostic register; mask keeps burst top bits at zero
    // RL17: burst top bits fixed
    always_ff @(posedge core_clk)
    begin
        if (rst)
            diag_r <= BCD_RESET_VAL;
        else if (cfg_wr && cfg_addr == BCD_OFF_CHIP_DIAG)
            diag_r <= (diag_r & ~(be_mask & BCD_DIAG_WMASK))
                      | (cfg_wdata & be_mask & BCD_DIAG_WMASK);
    end

    // read data registered; unmapped offsets read zero
    // RL21: config readback
    always_ff @(posedge core_clk)
    begin
        if (rst)
            cfg_rdata <= BCD_RESET_VAL;
        else if (cfg_rd)
        begin
            if (cfg_addr == BCD_OFF_BRIDGE_CTL)
                cfg_rdata <= bcd_bridge_view(bridge_r); // RL1 RL14 forced fields
            else if (cfg_addr == BCD_OFF_CHIP_DIAG)
                cfg_rdata <= diag_r & BCD_DIAG_WMASK;
            else
                cfg_rdata <= 32'h0000_0000;
        end
    end

    // RL3: reset output follows bit
    always_ff @(posedge core_clk)
    begin
        if (rst)
            sec_rst_q_r <= 1'b0;
        else
            sec_rst_q_r <= sec_reset_bit;
    end

    assign sec_rst_n     = !sec_reset_bit;
    // RL2: float and terminate
    assign sec_out_float = sec_reset_bit;
    assign sec_xact_kill = sec_reset_bit;
    // RL5: flush on rising edge of the bit
    assign post_flush    = sec_reset_bit && !sec_rst_q_r;
    // RL1: no fast back-to-back
    assign fast_b2b_allow = 1'b0;
    // RL13: parity check gate
    assign sec_parity_check_en = bridge_r[BCD_B_PAR_RESP];

    // RL8: vga and isa forwarding filter
    // RL9: vga beside windows
    // RL10: isa alias block
    // RL11: isa inside window
    bcd_fwd_decode u_dec (
        .is_io     (dec_is_io),
        .addr      (dec_addr),
        .in_window (dec_in_window),
        .vga_en    (bridge_r[BCD_B_VGA_EN]),
        .isa_en    (bridge_r[BCD_B_ISA_EN]),
        .forward   (dec_forward)
    );

    // master abort outcome chosen combinationally; posted writes not ours
    // RL6: target abort mode
    always_comb
    begin
        if (!ma_seen || ma_is_posted)
            ma_outcome = BCD_MA_NONE;
        else if (bridge_r[BCD_B_MA_MODE])
            ma_outcome = BCD_MA_TABORT;
        else if (ma_is_read)
            ma_outcome = BCD_MA_ONES;
        else
            ma_outcome = BCD_MA_DROP;
    end

    // RL7: all-ones read data
    always_ff @(posedge core_clk)
    begin
        if (rst)
            ma_data_r <= BCD_RESET_VAL;
        else if (ma_seen && ma_is_read && !bridge_r[BCD_B_MA_MODE])
            ma_data_r <= BCD_ALL_ONES;
    end
    assign ma_read_data = ma_data_r;

    // RL16: burst counting; zero limit never stops
    assign burst_lim = diag_r[BCD_D_BURST_LSB +: 6];
    always_ff @(posedge core_clk)
    begin
        if (rst)
            burst_cnt_r <= 7'h00;
        else if (burst_start)
            burst_cnt_r <= 7'h00;
        else if (burst_xfer && burst_cnt_r != 7'h7F)
            burst_cnt_r <= burst_cnt_r + 7'h01;
    end
    assign burst_stop = (burst_lim != 6'h00) && (burst_cnt_r >= {1'b0, burst_lim});

    // primary serr: diagnostic, forwarded secondary serr, unsuppressed posted errors
    // RL12: serr forward
    // RL15: per-condition suppress
    // RL18: diagnostic serr
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pri_serr_n_r <= 1'b1;
        else
            pri_serr_n_r <= !((diag_r[BCD_D_PSERR_DIAG] && pri_addr_phase)
                || (bridge_r[BCD_B_SERR_FWD] && sec_addr_par_serr)
                || |(pw_err & ~diag_r[BCD_D_PWE_HI:BCD_D_PWE_LO]));
    end
    assign pri_serr_n = pri_serr_n_r;

    // RL19: secondary perr diagnostic
    always_ff @(posedge core_clk)
    begin
        if (rst)
            sec_perr_n_r <= 1'b1;
        else
            sec_perr_n_r <= !(diag_r[BCD_D_SPERR_DIAG] && sec_wr_data_phase_us
                              && !sec_reset_bit);
    end
    assign sec_perr_n = sec_perr_n_r;

    // RL20: primary perr diagnostic
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pri_perr_n_r <= 1'b1;
        else
            pri_perr_n_r <= !(diag_r[BCD_D_PPERR_DIAG] && pri_wr_data_phase_us);
    end
    assign pri_perr_n = pri_perr_n_r;

    // assertions: secondary reset, flush and config survival
    a_sec_reset_out: assert property (@(posedge core_clk) disable iff (rst) // RL2
        sec_reset_bit |-> !sec_rst_n && sec_out_float)
        else $error("secondary reset not asserted");
    a_kill_on_reset: assert property (@(posedge core_clk) disable iff (rst) // RL2
        sec_reset_bit |-> sec_xact_kill)
        else $error("secondary transaction not ended");
    a_reset_held: assert property (@(posedge core_clk) disable iff (rst) // RL3
        (sec_reset_bit && !(cfg_wr && cfg_addr == BCD_OFF_BRIDGE_CTL)) |=> sec_reset_bit)
        else $error("secondary reset released without config write");
    a_cfg_alive: assert property (@(posedge core_clk) disable iff (rst) // RL4
        (sec_reset_bit && cfg_rd && cfg_addr == BCD_OFF_BRIDGE_CTL)
        |=> cfg_rdata[BCD_B_SEC_RESET])
        else $error("config read lost during secondary reset");
    a_cfg_kept: assert property (@(posedge core_clk) disable iff (rst) // RL4
        (sec_reset_bit && !(cfg_wr && cfg_addr == BCD_OFF_CHIP_DIAG)) |=> $stable(diag_r))
        else $error("config state changed during secondary reset");
    a_flush_once: assert property (@(posedge core_clk) disable iff (rst) // RL5
        $rose(sec_reset_bit) |-> post_flush ##1 !post_flush)
        else $error("flush pulse wrong");
    a_flush_cause: assert property (@(posedge core_clk) disable iff (rst) // RL5
        post_flush |-> $rose(sec_reset_bit))
        else $error("flush without reset bit rising");

    // master abort outcome checks
    a_ma_tabort: assert property (@(posedge core_clk) disable iff (rst) // RL6
        (ma_seen && !ma_is_posted && bridge_r[BCD_B_MA_MODE]) |-> ma_outcome == BCD_MA_TABORT)
        else $error("target abort not chosen");
    a_ma_ones: assert property (@(posedge core_clk) disable iff (rst) // RL7
        (ma_seen && ma_is_read && !bridge_r[BCD_B_MA_MODE]) |=> ma_read_data == BCD_ALL_ONES)
        else $error("aborted read data not all ones");
    a_ma_drop: assert property (@(posedge core_clk) disable iff (rst) // RL7
        (ma_seen && !ma_is_posted && !ma_is_read && !bridge_r[BCD_B_MA_MODE])
        |-> ma_outcome == BCD_MA_DROP)
        else $error("aborted write not dropped");

    // forwarding decode checks; vga io cases taken outside the window on purpose
    a_vga_mem: assert property (@(posedge core_clk) disable iff (rst) // RL8
        (bridge_r[BCD_B_VGA_EN] && !dec_is_io && dec_addr >= BCD_VGA_MEM_LO
         && dec_addr <= BCD_VGA_MEM_HI) |-> dec_forward)
        else $error("vga memory access not forwarded");
    a_vga_io: assert property (@(posedge core_clk) disable iff (rst) // RL9
        (bridge_r[BCD_B_VGA_EN] && dec_is_io && !dec_in_window && dec_addr >= BCD_VGA_IO_LO
         && dec_addr < BCD_VGA_HOLE_LO) |-> dec_forward)
        else $error("vga io access not forwarded");
    a_vga_hole: assert property (@(posedge core_clk) disable iff (rst) // RL8
        (dec_is_io && !dec_in_window && dec_addr >= BCD_VGA_HOLE_LO
         && dec_addr <= BCD_VGA_HOLE_HI) |-> !dec_forward)
        else $error("vga hole forwarded");
    a_isa_block: assert property (@(posedge core_clk) disable iff (rst) // RL10
        (bridge_r[BCD_B_ISA_EN] && !bridge_r[BCD_B_VGA_EN] && dec_is_io
         && dec_addr[BCD_ISA_LSB+1:BCD_ISA_LSB] != 2'b00) |-> !dec_forward)
        else $error("isa alias forwarded");
    a_isa_io_only: assert property (@(posedge core_clk) disable iff (rst) // RL11
        (dec_in_window && (!dec_is_io || !bridge_r[BCD_B_ISA_EN]
         || dec_addr[BCD_ISA_LSB+1:BCD_ISA_LSB] == 2'b00)) |-> dec_forward)
        else $error("window access wrongly filtered");

    // primary error reporting checks
    a_serr_fwd: assert property (@(posedge core_clk) disable iff (rst) // RL12
        (bridge_r[BCD_B_SERR_FWD] && sec_addr_par_serr) |=> !pri_serr_n)
        else $error("secondary serr not forwarded");
    a_pw_report: assert property (@(posedge core_clk) disable iff (rst) // RL15
        (|(pw_err & ~diag_r[BCD_D_PWE_HI:BCD_D_PWE_LO])) |=> !pri_serr_n)
        else $error("posted-write error not reported");
    a_pw_suppress: assert property (@(posedge core_clk) disable iff (rst) // RL15
        (pw_err != 4'h0 && (pw_err & ~diag_r[BCD_D_PWE_HI:BCD_D_PWE_LO]) == 4'h0
         && !(diag_r[BCD_D_PSERR_DIAG] && pri_addr_phase)
         && !(bridge_r[BCD_B_SERR_FWD] && sec_addr_par_serr)) |=> pri_serr_n)
        else $error("suppressed posted-write error reported");
    a_par_gate: assert property (@(posedge core_clk) disable iff (rst) // RL13
        !bridge_r[BCD_B_PAR_RESP] |-> !sec_parity_check_en)
        else $error("parity check on while response low");

    // readback checks
    a_fb2b_zero: assert property (@(posedge core_clk) disable iff (rst) // RL1
        (cfg_rd && cfg_addr == BCD_OFF_BRIDGE_CTL) |=> !cfg_rdata[BCD_B_FAST_B2B])
        else $error("fast back-to-back bit not zero");
    a_intpin_zero: assert property (@(posedge core_clk) disable iff (rst) // RL14
        (cfg_rd && cfg_addr == BCD_OFF_BRIDGE_CTL) |=> cfg_rdata[15:8] == BCD_INTPIN_VAL)
        else $error("interrupt pin field not zero");
    a_rsvd_bridge: assert property (@(posedge core_clk) disable iff (rst) // RL21
        (cfg_rd && cfg_addr == BCD_OFF_BRIDGE_CTL)
        |=> (cfg_rdata & ~BCD_BRIDGE_WMASK) == 32'h0000_0000)
        else $error("bridge reserved bits not zero");
    a_rsvd_diag: assert property (@(posedge core_clk) disable iff (rst) // RL21
        (cfg_rd && cfg_addr == BCD_OFF_CHIP_DIAG)
        |=> (cfg_rdata & ~BCD_DIAG_WMASK) == 32'h0000_0000)
        else $error("diagnostic reserved bits not zero");
    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst) // RL21
        (cfg_rd && cfg_addr != BCD_OFF_BRIDGE_CTL && cfg_addr != BCD_OFF_CHIP_DIAG)
        |=> cfg_rdata == 32'h0000_0000)
        else $error("unmapped offset not zero");

    // burst and diagnostic checks
    a_burst_cap: assert property (@(posedge core_clk) disable iff (rst) // RL16
        (burst_lim != 6'h00 && burst_cnt_r == {1'b0, burst_lim}) |-> burst_stop)
        else $error("burst not stopped at limit");
    a_burst_reach: assert property (@(posedge core_clk) disable iff (rst) // RL16
        (burst_lim != 6'h00 && !burst_start && burst_xfer
         && burst_cnt_r == {1'b0, burst_lim} - 7'h01
         && !(cfg_wr && cfg_addr == BCD_OFF_CHIP_DIAG)) |=> burst_stop)
        else $error("burst limit not reached by counting");
    a_burst_top: assert property (@(posedge core_clk) disable iff (rst) // RL17
        diag_r[BCD_D_BURST_LSB+7:BCD_D_BURST_LSB+6] == 2'b00)
        else $error("burst top bits set");
    a_serr_diag: assert property (@(posedge core_clk) disable iff (rst) // RL18
        (diag_r[BCD_D_PSERR_DIAG] && pri_addr_phase) |=> !pri_serr_n)
        else $error("diagnostic serr missing");
    a_sperr_diag: assert property (@(posedge core_clk) disable iff (rst) // RL19
        (diag_r[BCD_D_SPERR_DIAG] && sec_wr_data_phase_us && !sec_reset_bit) |=> !sec_perr_n)
        else $error("diagnostic secondary perr missing");
    a_pperr_diag: assert property (@(posedge core_clk) disable iff (rst) // RL20
        (diag_r[BCD_D_PPERR_DIAG] && pri_wr_data_phase_us) |=> !pri_perr_n)
        else $error("diagnostic primary perr missing");
endmodule : bcd_regs
`default_nettype wire

// file: sim/bcd_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module bcd_bus_model (
    input  wire logic        core_clk,
    output logic             dec_is_io,
    output logic [31:0]      dec_addr,
    output logic             dec_in_window,
    output logic             ma_seen,
    output logic             ma_is_read,
    output logic             ma_is_posted,
    output logic             burst_start,
    output logic             burst_xfer,
    output logic             sec_addr_par_serr,
    output logic [3:0]       pw_err,
    output logic             pri_addr_phase,
    output logic             sec_wr_data_phase_us,
    output logic             pri_wr_data_phase_us
);
    // vga window edges; plain random addresses rarely land on them
    localparam logic [31:0] EDGE [8] = '{32'h000A_0000, 32'h000B_FFFF, 32'h0009_FFFF,
        32'h0000_03BB, 32'h0000_03BC, 32'h0000_03BF, 32'h0000_03DF, 32'h0000_03E0};
    integer      pseed = 67490;
    logic [31:0] r;

    // quiet bus until the first falling edge
    initial
    begin
        {dec_is_io, dec_addr, dec_in_window, ma_seen, ma_is_read, ma_is_posted} = '0;
        {burst_start, burst_xfer, sec_addr_par_serr, pw_err} = '0;
        {pri_addr_phase, sec_wr_data_phase_us, pri_wr_data_phase_us} = '0;
    end

    // bus events move on the falling edge, away from sampling
    always @(negedge core_clk)
    begin
        r = $random(pseed);
        {dec_is_io, dec_in_window, ma_seen, ma_is_read, ma_is_posted} <= r[4:0];
        {sec_addr_par_serr, pw_err, pri_addr_phase} <= r[10:5];
        {sec_wr_data_phase_us, pri_wr_data_phase_us} <= r[12:11];
        burst_start <= r[15:13] == 3'h0;     // restarts often so the count stays short
        burst_xfer  <= r[15:13] != 3'h0 && r[16];
        dec_addr    <= r[17] ? EDGE[r[20:18]] : {12'h000, r[31:12]};
    end
endmodule : bcd_bus_model
`default_nettype wire

// file: sim/test_bridge_control_diag_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_bridge_control_diag_regs
    import bcd_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [7:0]  cfg_addr = 8'h00;
    logic [3:0]  cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic [31:0] cfg_rdata, ma_read_data, dec_addr, m3c, m40, e_rd, k, e_ma;
    logic [3:0]  pw_err;
    logic [1:0]  ma_outcome;
    logic        sec_rst_n, sec_out_float, sec_xact_kill, post_flush, fast_b2b_allow;
    logic        sec_parity_check_en, dec_is_io, dec_in_window, dec_forward, burst_stop;
    logic        ma_seen, ma_is_read, ma_is_posted, burst_start, burst_xfer;
    logic        sec_addr_par_serr, pri_addr_phase, sec_wr_data_phase_us, pri_wr_data_phase_us;
    logic        pri_serr_n, sec_perr_n, pri_perr_n, p22, rd_due, ma_due, e_ps, e_sp, e_pp;
    integer      seed = 67490;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cnt;
    logic [7:0]  sel [4] = '{8'h3C, 8'h40, 8'h44, 8'h3C};

    bcd_regs u_dut (.core_clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
        .sec_rst_n, .sec_out_float, .sec_xact_kill, .post_flush, .fast_b2b_allow,
        .sec_parity_check_en, .dec_is_io, .dec_addr, .dec_in_window, .dec_forward, .ma_seen,
        .ma_is_read, .ma_is_posted, .ma_outcome, .ma_read_data, .burst_start, .burst_xfer,
        .burst_stop, .sec_addr_par_serr, .pw_err, .pri_addr_phase, .sec_wr_data_phase_us,
        .pri_wr_data_phase_us, .pri_serr_n, .sec_perr_n, .pri_perr_n);

    bcd_bus_model u_bus (.core_clk, .dec_is_io, .dec_addr, .dec_in_window, .ma_seen,
        .ma_is_read, .ma_is_posted, .burst_start, .burst_xfer, .sec_addr_par_serr, .pw_err,
        .pri_addr_phase, .sec_wr_data_phase_us, .pri_wr_data_phase_us);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    function automatic logic [31:0] f_merge(input logic [31:0] o, w, m, input logic [3:0] be);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
        return (o & ~bm) | (w & bm);
    endfunction : f_merge

    // vga decode stands apart from the window; isa hole only inside it
    function automatic logic f_fwd(input logic io, inw, vga, isa, input logic [31:0] a);
        logic hit;
        hit = io ? (a >= 32'h0000_03B0 && a <= 32'h0000_03DF
                    && !(a >= 32'h0000_03BC && a <= 32'h0000_03BF))
                 : (a >= 32'h000A_0000 && a <= 32'h000B_FFFF);
        return (vga && hit) || (inw && !(isa && io && a[9:8] != 2'h0));
    endfunction : f_fwd

    function automatic logic [1:0] f_ma(input logic s, rd, po, mode);
        if (!s || po)
            return 2'h0;
        return mode ? 2'h1 : (rd ? 2'h2 : 2'h3);
    endfunction : f_ma

    // one request per falling edge; the two strobes are never both raised in one step
    task automatic op(input logic w, r, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(negedge core_clk);
        cfg_wr = w;
        cfg_rd = r;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
    endtask : op

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp);
        op(1'b0, 1'b1, a, 4'hF, 32'h0000_0000);
        op(1'b0, 1'b0, a, 4'hF, 32'h0000_0000);
        check(cfg_rdata, exp);
    endtask : rd_exp

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    // reference runs on the sampling edge and reads old state before updating it
    always @(posedge core_clk)
    begin
        if (!rst)
        begin
            check(pri_serr_n, e_ps);
            check(sec_perr_n, e_sp);
            check(pri_perr_n, e_pp);
            check({sec_rst_n, sec_out_float, sec_xact_kill}, {~m3c[22], {2{m3c[22]}}});
            check(post_flush, m3c[22] & ~p22);
            check(fast_b2b_allow, 1'b0);
            check(sec_parity_check_en, m3c[16]);
            check(dec_forward, f_fwd(dec_is_io, dec_in_window, m3c[19], m3c[18], dec_addr));
            check(ma_outcome, f_ma(ma_seen, ma_is_read, ma_is_posted, m3c[21]));
            check(burst_stop, m40[21:16] != 6'h00 && cnt >= m40[21:16]);
            if (rd_due)
                check(cfg_rdata, e_rd);
            check(ma_read_data, e_ma);
            if (ma_due)
                check(ma_read_data, BCD_ALL_ONES);
        end
        rd_due = cfg_rd && !rst;
        e_rd = cfg_addr == 8'h3C ? m3c : (cfg_addr == 8'h40 ? m40 : 32'h0000_0000);
        ma_due = ma_seen && ma_is_read && !ma_is_posted && !m3c[21] && !rst;
        e_ma = rst ? 32'h0000_0000
                   : ((ma_seen && ma_is_read && !m3c[21]) ? BCD_ALL_ONES : e_ma);
        e_ps = rst || !((pri_addr_phase && m40[12]) || (sec_addr_par_serr && m3c[17])
                        || |(pw_err & ~m40[28:25]));
        e_sp = rst || !(sec_wr_data_phase_us && m40[11] && !m3c[22]);
        e_pp = rst || !(pri_wr_data_phase_us && m40[10]);
        cnt = (rst || burst_start) ? 0 : cnt + int'(burst_xfer);
        p22 = !rst && m3c[22];
        if (rst)
            {m3c, m40} = '0;
        else if (cfg_wr && cfg_addr == 8'h3C)
            m3c = f_merge(m3c, cfg_wdata, BCD_BRIDGE_WMASK, cfg_be);
        else if (cfg_wr && cfg_addr == 8'h40)
            m40 = f_merge(m40, cfg_wdata, BCD_DIAG_WMASK, cfg_be);
    end

    initial
    begin
        #200000;
        n_mismatch++;
        wrap_up;
    end

    initial
    begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        rd_exp(8'h3C, 32'h0000_0000);
        rd_exp(8'h40, 32'h0000_0000);
        op(1'b1, 1'b0, 8'h3C, 4'hF, 32'hFFFF_FFFF);
        rd_exp(8'h3C, 32'h006F_0000);
        op(1'b1, 1'b0, 8'h40, 4'hF, 32'hFFFF_FFFF);
        rd_exp(8'h40, 32'h1E3F_1C00);
        rd_exp(8'h44, 32'h0000_0000);
        for (int i = 0; i < 3000; i++)
        begin
            k = $random(seed);
            op(k[0] & ~k[1], k[1] & ~k[0], sel[k[3:2]], k[7:4], $random(seed));
            rst = i >= 1500 && i < 1504;
        end
        op(1'b0, 1'b0, 8'h3C, 4'h0, 32'h0000_0000);
        wrap_up;
    end
endmodule : test_bridge_control_diag_regs
`default_nettype wire
